// file: src/mbd_top.sv
// Demultiplexing display latch for a multiplexed BCD converter
`timescale 1ns/1ps
`default_nettype none
module mbd_top (
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    input  wire logic [3:0] i_data,
    input  wire logic       i_first_digit_strobe,
    input  wire logic       i_second_digit_strobe,
    input  wire logic       i_third_digit_strobe,
    input  wire logic       i_fourth_digit_strobe,
    input  wire logic       i_overrange_n,
    input  wire logic       i_end_of_conv,
    output logic      [6:0] o_seg_first,
    output logic      [6:0] o_seg_second,
    output logic      [6:0] o_seg_third,
    output logic      [6:0] o_seg_fourth,
    output logic            o_first_position_seg_a,
    output logic            o_first_position_seg_c,
    output logic            o_first_position_seg_f,
    output logic            o_overrange_flag,
    output logic            o_underrange_flag,
    output logic            o_flash
);

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [3:0]      data_s1;
        logic [3:0]      data_s2;
        logic [3:0]      data_s3;
        logic [3:0]      data_f;
        logic [3:0]      stb_s1;
        logic [3:0]      stb_s2;
        logic [3:0]      stb_s3;
        logic [3:0]      stb_f;
        logic [2:0]      ovr_s;
        logic            ovr_f;
        logic [2:0]      eoc_s;
        logic            eoc_f;
        logic [3:0][3:0] latch;
        logic [3:0][6:0] seg;
        logic            first_a;
        logic            first_c;
        logic            first_f;
        logic            over;
        logic            under;
        logic            flash;
    } mbd_state_type;

    mbd_state_type st_ff;
    mbd_state_type nxt_st;

    logic [3:0]      cap;
    logic            eoc_rise;
    logic [3:0][6:0] dec_seg;

    ////////////////////////////////////////////////////////////////////////
    // Static decoders, one per latch

    genvar gi;
    generate
        for (gi = 0; gi < mbd_pkg::DIG_N; gi++) begin : g_dec
            mbd_seg_decode u_dec (
                .i_bcd (st_ff.latch[gi]),
                .o_seg (dec_seg[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Next state

    // Pin filter: a change counts once stages two and three agree
    function automatic logic [3:0] agree4(input logic [3:0] s2,
                                          input logic [3:0] s3,
                                          input logic [3:0] f);
        agree4 = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & f);
    endfunction

    always_comb begin
        nxt_st = st_ff;

        nxt_st.data_s1 = i_data;
        nxt_st.data_s2 = st_ff.data_s1;
        nxt_st.data_s3 = st_ff.data_s2;
        nxt_st.data_f  = agree4(st_ff.data_s2, st_ff.data_s3, st_ff.data_f);

        nxt_st.stb_s1 = {i_fourth_digit_strobe, i_third_digit_strobe,
                         i_second_digit_strobe, i_first_digit_strobe};
        nxt_st.stb_s2 = st_ff.stb_s1;
        nxt_st.stb_s3 = st_ff.stb_s2;
        nxt_st.stb_f  = agree4(st_ff.stb_s2, st_ff.stb_s3, st_ff.stb_f);

        nxt_st.ovr_s = {st_ff.ovr_s[1:0], i_overrange_n};
        if (st_ff.ovr_s[1] == st_ff.ovr_s[2]) begin
            nxt_st.ovr_f = st_ff.ovr_s[2];
        end
        nxt_st.eoc_s = {st_ff.eoc_s[1:0], i_end_of_conv};
        if (st_ff.eoc_s[1] == st_ff.eoc_s[2]) begin
            nxt_st.eoc_f = st_ff.eoc_s[2];
        end

        // Data and strobes share the same filter delay, so the data seen
        // with a strobe's rise is the data that stood at the pin with it
        cap      = nxt_st.stb_f & ~st_ff.stb_f;
        eoc_rise = nxt_st.eoc_f & ~st_ff.eoc_f;

        for (int i = 0; i < mbd_pkg::DIG_N; i++) begin
            if (cap[i]) begin
                if (i == mbd_pkg::MSD_SLOT) begin
                    // Sign moves to bit one inverted, so -1 decodes as 7
                    // and +1 as 5 on the first position
                    nxt_st.latch[i][mbd_pkg::HALF_BIT] =
                        nxt_st.data_f[mbd_pkg::HALF_BIT];
                    nxt_st.latch[i][mbd_pkg::SIGN_BIT]  = 1'b1;
                    nxt_st.latch[i][mbd_pkg::REMAP_BIT] =
                        ~nxt_st.data_f[mbd_pkg::SIGN_BIT];
                    nxt_st.latch[i][mbd_pkg::RANGE_BIT] = 1'b1;
                end else begin
                    nxt_st.latch[i] = nxt_st.data_f;
                end
            end
        end

        if (cap[mbd_pkg::MSD_SLOT]) begin
            nxt_st.over  = nxt_st.data_f[mbd_pkg::RANGE_BIT] &
                           ~nxt_st.data_f[mbd_pkg::HALF_BIT];
            nxt_st.under = nxt_st.data_f[mbd_pkg::RANGE_BIT] &
                           nxt_st.data_f[mbd_pkg::HALF_BIT];
        end

        // In range holds the flop clear; out of range it toggles per EOC
        if (st_ff.ovr_f) begin
            nxt_st.flash = 1'b0;
        end else if (eoc_rise) begin
            nxt_st.flash = ~st_ff.flash;
        end

        for (int i = 0; i < mbd_pkg::DIG_N; i++) begin
            if (st_ff.flash) begin
                nxt_st.seg[i] = mbd_pkg::SEG_BLANK;
            end else begin
                nxt_st.seg[i] = dec_seg[i];
            end
        end

        // Half digit on a and c, plus sign on f of the first position
        nxt_st.first_a = nxt_st.seg[mbd_pkg::MSD_SLOT][mbd_pkg::SEG_A];
        nxt_st.first_c = nxt_st.seg[mbd_pkg::MSD_SLOT][mbd_pkg::SEG_C];
        nxt_st.first_f = nxt_st.seg[mbd_pkg::MSD_SLOT][mbd_pkg::SEG_F];
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            st_ff         <= '0;
            st_ff.ovr_s   <= mbd_pkg::OVR_SYNC_RST;
            st_ff.ovr_f   <= mbd_pkg::OVR_RST;
            st_ff.latch   <= {mbd_pkg::DIG_N{mbd_pkg::RST_DIG}};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_seg_first            = st_ff.seg[0];
    assign o_seg_second           = st_ff.seg[1];
    assign o_seg_third            = st_ff.seg[2];
    assign o_seg_fourth           = st_ff.seg[3];
    assign o_first_position_seg_a = st_ff.first_a;
    assign o_first_position_seg_c = st_ff.first_c;
    assign o_first_position_seg_f = st_ff.first_f;
    assign o_overrange_flag       = st_ff.over;
    assign o_underrange_flag      = st_ff.under;
    assign o_flash                = st_ff.flash;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    a_msd_remap: assert property (
        @(posedge i_clk) disable iff (i_reset)
        cap[0] |=> (st_ff.latch[0][0] && st_ff.latch[0][2] &&
                    st_ff.latch[0][1] == !st_ff.data_f[2] &&
                    st_ff.latch[0][3] == st_ff.data_f[3]))
        else $error("MSD code not remapped");

    a_digit_pass: assert property (
        @(posedge i_clk) disable iff (i_reset)
        cap[1] |=> st_ff.latch[1] == st_ff.data_f)
        else $error("Second digit not captured unchanged");

    a_latch_hold: assert property (
        @(posedge i_clk) disable iff (i_reset)
        !cap[2] |=> $stable(st_ff.latch[2]))
        else $error("Third latch changed without its strobe");

    a_invalid_blank: assert property (
        @(posedge i_clk) disable iff (i_reset)
        st_ff.latch[3] > 4'h9 |=> st_ff.seg[3] == 7'h00)
        else $error("Invalid code not blanked");

    a_range_class: assert property (
        @(posedge i_clk) disable iff (i_reset)
        cap[0] && nxt_st.data_f[0] |=>
            (st_ff.over == !st_ff.data_f[3]) &&
            (st_ff.under == st_ff.data_f[3]))
        else $error("Range condition misclassified");

    a_flash_clear: assert property (
        @(posedge i_clk) disable iff (i_reset)
        st_ff.ovr_f |=> !st_ff.flash)
        else $error("Flash flop not held clear in range");

    a_flash_toggle: assert property (
        @(posedge i_clk) disable iff (i_reset)
        !st_ff.ovr_f && eoc_rise |=> st_ff.flash != $past(st_ff.flash))
        else $error("Flash flop missed a toggle");

    a_flash_blank: assert property (
        @(posedge i_clk) disable iff (i_reset)
        st_ff.flash |=> (o_seg_first == 7'h00 && o_seg_second == 7'h00 &&
                         o_seg_third == 7'h00 && o_seg_fourth == 7'h00))
        else $error("Digits lit while flashing off");

    a_first_segs: assert property (
        @(posedge i_clk) disable iff (i_reset)
        o_first_position_seg_a == o_seg_first[6] &&
        o_first_position_seg_c == o_seg_first[4] &&
        o_first_position_seg_f == o_seg_first[1])
        else $error("First position segment outputs disagree");

    a_half_sign: assert property (
        @(posedge i_clk) disable iff (i_reset)
        !st_ff.flash && st_ff.latch[0] inside {4'h5, 4'h7} |=>
            o_first_position_seg_a && o_first_position_seg_c &&
            o_first_position_seg_f == !$past(st_ff.latch[0][1]))
        else $error("Half digit or plus sign not lit");

endmodule
`default_nettype wire

// file: inc/mbd_pkg.sv
// Constants for the multiplexed BCD display latch
package mbd_pkg;
    localparam int DIG_W    = 4;
    localparam int DIG_N    = 4;
    localparam int SEG_W    = 7;

    // Digit slot that carries the half digit, sign and range flags
    localparam int MSD_SLOT = 0;

    // Fields of the most significant digit code
    localparam int HALF_BIT   = 3;
    localparam int SIGN_BIT   = 2;
    localparam int REMAP_BIT  = 1;
    localparam int RANGE_BIT  = 0;

    // Segment positions within a segment word, a in the top bit
    localparam int SEG_A = 6;
    localparam int SEG_C = 4;
    localparam int SEG_F = 1;

    localparam logic [DIG_W-1:0] LAST_BCD  = 4'h9;
    localparam logic [DIG_W-1:0] RST_DIG   = 4'hF;
    // Overrange synchroniser idles at in range so reset does not flash
    localparam logic [2:0]       OVR_SYNC_RST = 3'h7;
    localparam logic             OVR_RST      = 1'b1;
    localparam logic [SEG_W-1:0] SEG_BLANK = 7'h00;

    // Segment patterns abcdefg for digits 9 down to 0
    localparam logic [9:0][SEG_W-1:0] SEG_TABLE = {
        7'h73, 7'h7F, 7'h70, 7'h5F, 7'h5B,
        7'h33, 7'h79, 7'h6D, 7'h30, 7'h7E
    };
endpackage

// file: src/mbd_seg_decode.sv
// BCD to seven-segment decoder that blanks invalid codes
`timescale 1ns/1ps
`default_nettype none
module mbd_seg_decode (
    input  wire logic [3:0] i_bcd,
    output logic      [6:0] o_seg
);
    always_comb begin
        if (i_bcd > mbd_pkg::LAST_BCD) begin
            o_seg = mbd_pkg::SEG_BLANK;
        end else begin
            o_seg = mbd_pkg::SEG_TABLE[i_bcd];
        end
    end
endmodule
`default_nettype wire

// file: bench/mbd_conv_model.sv
// Converter model: multiplexed digits, strobes, overrange, end of conversion
`timescale 1ns/1ps
`default_nettype none
module mbd_conv_model (
    input  wire logic       i_clk,
    output logic      [3:0] o_data,
    output logic      [3:0] o_strobe,
    output logic            o_overrange_n,
    output logic            o_end_of_conv
);
    initial begin
        o_data = 4'h0;
        o_strobe = 4'h0;
        o_overrange_n = 1'b1;
        o_end_of_conv = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Data settles before the strobe; afterwards the lines show junk, not
    // the old digit, so a late capture cannot pass by luck
    task automatic send_digit(input int idx, input logic [3:0] val);
        o_data = val;
        hold(5);
        o_strobe[idx] = 1'b1;
        hold(5);
        o_strobe[idx] = 1'b0;
        hold(2);
        o_data = ~val;
        hold(4);
    endtask

    task automatic pulse_eoc();
        o_end_of_conv = 1'b1;
        hold(5);
        o_end_of_conv = 1'b0;
        hold(5);
    endtask

    // o_overrange_n starts high, in range, until an out-of-range conversion is set here
    task automatic set_range(input logic in_range);
        o_overrange_n = in_range;
        hold(8);
    endtask
endmodule
`default_nettype wire

// file: bench/mbd_top_tb_top.sv
// Self-checking bench for the multiplexed BCD display latch
`timescale 1ns/1ps
`default_nettype none
module mbd_top_tb_top;
    logic       clk = 1'b0;
    logic       reset = 1'b1;
    logic [3:0] data;
    logic [3:0] strobe;
    logic       ovr_n;
    logic       eoc;
    wire logic [3:0][6:0] segs;
    logic       seg_a, seg_c, seg_f, over, under, flash;
    logic [8:0] notes [$];
    logic [3:0] last [4];
    logic [7:0] lfsr = 8'h1C;
    int         miscompares = 0;
    int         check_count = 0;
    event       result;
    logic [3:0] lo [3]  = '{4'h9, 4'hA, 4'hF};
    logic [3:0] msd [6] = '{4'h0, 4'h4, 4'hE, 4'hA, 4'hB, 4'h7};

    always #10 clk = ~clk;

    mbd_conv_model model (.i_clk(clk), .o_data(data), .o_strobe(strobe),
        .o_overrange_n(ovr_n), .o_end_of_conv(eoc));

    mbd_top DUT (.i_clk(clk), .i_reset(reset), .i_data(data),
        .i_first_digit_strobe(strobe[0]), .i_second_digit_strobe(strobe[1]),
        .i_third_digit_strobe(strobe[2]), .i_fourth_digit_strobe(strobe[3]),
        .i_overrange_n(ovr_n), .i_end_of_conv(eoc),
        .o_seg_first(segs[0]), .o_seg_second(segs[1]),
        .o_seg_third(segs[2]), .o_seg_fourth(segs[3]),
        .o_first_position_seg_a(seg_a), .o_first_position_seg_c(seg_c),
        .o_first_position_seg_f(seg_f), .o_overrange_flag(over),
        .o_underrange_flag(under), .o_flash(flash));

    function automatic logic [6:0] seg_of(input logic [3:0] c);
        return (c > 4'h9) ? mbd_pkg::SEG_BLANK : mbd_pkg::SEG_TABLE[c];
    endfunction

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic check(input string name, input logic [6:0] seen,
                         input logic [6:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic send(input int idx, input logic [3:0] raw,
                        input logic [3:0] code);
        model.send_digit(idx, raw);
        last[idx] = code;
        notes.push_back({idx[1:0], seg_of(code)});
        ->result;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [8:0] n;
        forever begin
            @(result);
            while (notes.size() > 0) begin
                n = notes.pop_front();
                check("digit segments", segs[n[8:7]], n[6:0]);
            end
        end
    end

    // A hang ends the run as a mismatch
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        end_of_test();
    end

    initial begin
        logic [3:0] raw;
        logic [3:0] code;
        logic [6:0] exp;
        repeat (16) @(posedge clk);
        #1;
        reset = 1'b0;
        for (int i = 0; i < 15; i++) begin
            raw = (i < 3) ? lo[i] : lfsr[3:0];
            lfsr = lfsr_next(lfsr);
            send(1 + i % 3, raw, raw);
        end
        // Earlier digits must still stand after the others were written
        for (int d = 1; d < 4; d++) begin
            notes.push_back({d[1:0], seg_of(last[d])});
        end
        ->result;
        $display("test lower digits done");
        foreach (msd[k]) begin
            code = {msd[k][3], 1'b1, ~msd[k][2], 1'b1};
            send(0, msd[k], code);
            exp = seg_of(code);
            check("half a", 7'(seg_a), 7'(exp[mbd_pkg::SEG_A]));
            check("half c", 7'(seg_c), 7'(exp[mbd_pkg::SEG_C]));
            check("plus f", 7'(seg_f), 7'(exp[mbd_pkg::SEG_F]));
            check("over", 7'(over), 7'(msd[k][0] & ~msd[k][3]));
            check("under", 7'(under), 7'(msd[k][0] & msd[k][3]));
        end
        $display("test most significant digit done");
        model.set_range(1'b0);
        model.pulse_eoc();
        check("flash", 7'(flash), 7'h01);
        for (int d = 0; d < 4; d++) begin
            check("blanked", segs[d], mbd_pkg::SEG_BLANK);
        end
        check("plus f", 7'(seg_f), 7'h00);
        model.pulse_eoc();
        check("flash", 7'(flash), 7'h00);
        check("restored", segs[1], seg_of(last[1]));
        check("restored", segs[0], seg_of(last[0]));
        model.pulse_eoc();
        model.set_range(1'b1);
        check("flash", 7'(flash), 7'h00);
        check("restored", segs[2], seg_of(last[2]));
        $display("test flash done");
        end_of_test();
    end
endmodule
`default_nettype wire
